// file: logic/rspm_pkg.sv
// Shared constants for the reset-strap pin multiplexer.
// Assumes a 32-bit APB register port with word-aligned registers.
package rspm_pkg;
    // Register byte offsets
    localparam logic [7:0] RSPM_GPIO_EN_OFS = 8'h00;
    localparam logic [7:0] RSPM_GPIO_DIR_OFS = 8'h04;
    localparam logic [7:0] RSPM_GPIO_OUT_OFS = 8'h08;
    localparam logic [7:0] RSPM_GPIO_IN_OFS = 8'h0c;
    localparam logic [7:0] RSPM_STRAP_OFS = 8'h10;
    // Strap status fields
    localparam int RSPM_STRAP_WIDTH_BIT = 0;
    localparam int RSPM_STRAP_ATM_BIT = 1;
    localparam int RSPM_STRAP_PCI_BIT = 2;
    // Reset values of the software registers
    localparam logic [15:0] RSPM_GPIO_EN_RST = 16'h0000;
    localparam logic [15:0] RSPM_GPIO_DIR_RST = 16'h0000;
    localparam logic [15:0] RSPM_GPIO_OUT_RST = 16'h0000;
    // GPIO lines with a default peripheral: clock div4 (1), div6 (2), serial2 clock (8)
    localparam logic [15:0] RSPM_DEFAULT_ALT_MASK = 16'h0106;
    // GPIO lines that belong to the PCI function when its strap is set
    localparam logic [15:0] RSPM_PCI_GP_MASK = 16'hfe00;
    // Host data pin that carries the bus width strap
    localparam int RSPM_WIDTH_STRAP_PIN = 5;
    // Number of synchroniser stages on pin inputs
    localparam int RSPM_SYNC_STAGES = 2;
endpackage : rspm_pkg

// file: logic/rspm_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to mclk; no reset so straps flow during reset.
`timescale 1ns/1ns
`default_nettype none
module rspm_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic mclk,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    // First stage is read only by the second stage
    always_ff @(posedge mclk) begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
endmodule : rspm_sync
`default_nettype wire

// file: logic/rspm_top.sv
// Reset-strap pin multiplexer: straps, host data width, GPIO sharing, serial/ATM and PCI pins.
// Assumes an APB master on mclk, synchronous active-low reset held at least 3 edges,
// and board straps stable while reset is low.
//
// How it works
// R1 - Width strap 0 gives a 16-bit host port; upper host data pins float unless the PCI strap is high.
// R2 - Width strap 1 gives a 32-bit host port using all host data pins while the PCI strap is low.
// R3 - Software GPIO enable and direction may be rewritten at any time.
// R4 - Strap-selected functions come only from levels sampled at reset.
// R5 - Each strap-selected pin group has exactly one owning peripheral.
// R6 - After reset pins 1, 2, 8 carry div4 clock, div6 clock, serial2 clock.
// R7 - GPIO enable 1 hands the pin to GPIO instead of its peripheral, except PCI lines 9 to 15 under the PCI strap.
// R8 - Enabled GPIO pin is input with direction 0, output with direction 1.
// R9 - GPIO 9 to 15 usable only with PCI strap off and enable set.
// R10 - GPIO 9 to 15 have no default function; enables reset to 0.
// R11 - Shared serial-one and ATM address pins default to serial port one.
// R12 - ATM cell port stays disabled while its strap sampled 0.
// R13 - External drivers on other boot address pins keep reset defaults or float.
// R14 - ATM strap 1 gives shared pins to ATM and floats standalone serial-one pins.
// R15 - Shared host and PCI pins default to host port unless PCI strap is high.
// R16 - Straps are captured during reset, latched at release, held until next reset.
`timescale 1ns/1ns
`default_nettype none
module rspm_top
    import rspm_pkg::*;
#(
    parameter int GPIO_W = 16,
    parameter int SHARED_W = 4,
    parameter int SP1_SOLO_W = 4,
    parameter int ATM_SOLO_W = 4,
    parameter int HD_W = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap pins
    input wire logic atm_port_select_strap,
    input wire logic pci_func_strap,
    // Host data pins
    input wire logic [HD_W-1:0] host_data_pins_in,
    output logic [HD_W-1:0] host_data_pins_out,
    output logic [HD_W-1:0] host_data_pins_oe,
    // Host port and PCI engines on the host data pins
    input wire logic [HD_W-1:0] host_port_out,
    input wire logic [HD_W-1:0] host_port_oe,
    output logic [HD_W-1:0] host_port_in,
    input wire logic [HD_W-1:0] pci_ad_out,
    input wire logic [HD_W-1:0] pci_ad_oe,
    output logic [HD_W-1:0] pci_ad_in,
    // Mode status
    output logic host_port_16bit,
    output logic host_port_32bit,
    output logic pci_enable,
    output logic atm_enable,
    // GPIO pins
    input wire logic [GPIO_W-1:0] gpio_pins_in,
    output logic [GPIO_W-1:0] gpio_pins_out,
    output logic [GPIO_W-1:0] gpio_pins_oe,
    // Peripheral side of the GPIO pins (clock outputs, serial2 clock, PCI)
    input wire logic [GPIO_W-1:0] periph_gp_out,
    input wire logic [GPIO_W-1:0] periph_gp_oe,
    output logic [GPIO_W-1:0] periph_gp_in,
    // Shared serial-one / ATM address pins
    input wire logic [SHARED_W-1:0] shared_pins_in,
    output logic [SHARED_W-1:0] shared_pins_out,
    output logic [SHARED_W-1:0] shared_pins_oe,
    input wire logic [SHARED_W-1:0] sp1_shared_out,
    input wire logic [SHARED_W-1:0] sp1_shared_oe,
    output logic [SHARED_W-1:0] sp1_shared_in,
    input wire logic [SHARED_W-1:0] atm_shared_out,
    input wire logic [SHARED_W-1:0] atm_shared_oe,
    output logic [SHARED_W-1:0] atm_shared_in,
    // Standalone serial-one pins
    input wire logic [SP1_SOLO_W-1:0] sp1_solo_out,
    input wire logic [SP1_SOLO_W-1:0] sp1_solo_oe,
    output logic [SP1_SOLO_W-1:0] sp1_solo_pins_out,
    output logic [SP1_SOLO_W-1:0] sp1_solo_pins_oe,
    // Standalone ATM pins
    input wire logic [ATM_SOLO_W-1:0] atm_solo_out,
    input wire logic [ATM_SOLO_W-1:0] atm_solo_oe,
    output logic [ATM_SOLO_W-1:0] atm_solo_pins_out,
    output logic [ATM_SOLO_W-1:0] atm_solo_pins_oe
);
    import rspm_pkg::*;

    // Synchronised pin inputs
    logic atm_strap_s;
    logic pci_strap_s;
    logic [HD_W-1:0] hd_s;
    logic [GPIO_W-1:0] gp_s;
    logic [SHARED_W-1:0] sh_s;

    rspm_sync #(.WIDTH(2 + HD_W + GPIO_W + SHARED_W)) u_sync (
        .mclk(mclk),
        .async_in({atm_port_select_strap, pci_func_strap, host_data_pins_in,
                   gpio_pins_in, shared_pins_in}),
        .sync_out({atm_strap_s, pci_strap_s, hd_s, gp_s, sh_s})
    );

    // Latched straps
    logic width_q;
    logic atm_q;
    logic pci_q;

    // While reset is low the straps follow the pins; on release they freeze
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            width_q <= hd_s[RSPM_WIDTH_STRAP_PIN]; // see R16 see R4
            atm_q <= atm_strap_s; // see R16
            pci_q <= pci_strap_s; // see R16
        end
    end

    // Mode status outputs; straps are never written by software
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            host_port_16bit <= 1'b0;
            host_port_32bit <= 1'b0;
            pci_enable <= 1'b0;
            atm_enable <= 1'b0;
        end else begin
            host_port_16bit <= ~width_q; // see R1
            host_port_32bit <= width_q; // see R2
            pci_enable <= pci_q; // see R15
            atm_enable <= atm_q; // see R12
        end
    end

    // Software registers
    logic [GPIO_W-1:0] gp_en_q;
    logic [GPIO_W-1:0] gp_dir_q;
    logic [GPIO_W-1:0] gp_out_q;

    logic setup;
    logic access;
    logic mapped;
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign mapped = (paddr == RSPM_GPIO_EN_OFS) || (paddr == RSPM_GPIO_DIR_OFS) ||
                    (paddr == RSPM_GPIO_OUT_OFS) || (paddr == RSPM_GPIO_IN_OFS) ||
                    (paddr == RSPM_STRAP_OFS);

    // Writes land on the access edge, any time during operation
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            gp_en_q <= RSPM_GPIO_EN_RST[GPIO_W-1:0]; // see R6 see R10
            gp_dir_q <= RSPM_GPIO_DIR_RST[GPIO_W-1:0];
            gp_out_q <= RSPM_GPIO_OUT_RST[GPIO_W-1:0];
        end else if (access && pwrite) begin
            if (paddr == RSPM_GPIO_EN_OFS) begin
                gp_en_q <= pwdata[GPIO_W-1:0]; // see R3
            end
            if (paddr == RSPM_GPIO_DIR_OFS) begin
                gp_dir_q <= pwdata[GPIO_W-1:0]; // see R3
            end
            if (paddr == RSPM_GPIO_OUT_OFS) begin
                gp_out_q <= pwdata[GPIO_W-1:0];
            end
        end
    end

    // Read mux
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            RSPM_GPIO_EN_OFS: rdata_d[GPIO_W-1:0] = gp_en_q;
            RSPM_GPIO_DIR_OFS: rdata_d[GPIO_W-1:0] = gp_dir_q;
            RSPM_GPIO_OUT_OFS: rdata_d[GPIO_W-1:0] = gp_out_q;
            RSPM_GPIO_IN_OFS: rdata_d[GPIO_W-1:0] = gp_s;
            RSPM_STRAP_OFS: begin
                rdata_d[RSPM_STRAP_WIDTH_BIT] = width_q;
                rdata_d[RSPM_STRAP_ATM_BIT] = atm_q;
                rdata_d[RSPM_STRAP_PCI_BIT] = pci_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // One wait-free access: ready rises in the access cycle from the setup cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // GPIO pin ownership per line
    logic [GPIO_W-1:0] pci_own;
    logic [GPIO_W-1:0] alt_own;
    logic [GPIO_W-1:0] gpio_own;
    assign pci_own = pci_q ? RSPM_PCI_GP_MASK[GPIO_W-1:0] : {GPIO_W{1'b0}};
    // PCI lines cannot be taken by GPIO while the PCI strap holds them
    assign gpio_own = gp_en_q & ~pci_own; // see R7 see R9 see R5
    assign alt_own = (RSPM_DEFAULT_ALT_MASK[GPIO_W-1:0] | pci_own) & ~gpio_own; // see R6

    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi++) begin : g_gp
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    gpio_pins_out[gi] <= 1'b0;
                    gpio_pins_oe[gi] <= 1'b0;
                    periph_gp_in[gi] <= 1'b0;
                end else if (gpio_own[gi]) begin
                    gpio_pins_out[gi] <= gp_out_q[gi];
                    gpio_pins_oe[gi] <= gp_dir_q[gi]; // see R8
                    periph_gp_in[gi] <= 1'b0;
                end else if (alt_own[gi]) begin
                    gpio_pins_out[gi] <= periph_gp_out[gi]; // see R6
                    gpio_pins_oe[gi] <= periph_gp_oe[gi];
                    periph_gp_in[gi] <= gp_s[gi];
                end else begin
                    // No owner: pin floats, see R10
                    gpio_pins_out[gi] <= 1'b0;
                    gpio_pins_oe[gi] <= 1'b0;
                    periph_gp_in[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Host data pins: host port by default, PCI only with its strap
    logic [HD_W-1:0] hp_lane_mask;
    assign hp_lane_mask = width_q ? {HD_W{1'b1}} : {{(HD_W/2){1'b0}}, {(HD_W/2){1'b1}}};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            host_data_pins_out <= {HD_W{1'b0}};
            host_data_pins_oe <= {HD_W{1'b0}};
            host_port_in <= {HD_W{1'b0}};
            pci_ad_in <= {HD_W{1'b0}};
        end else if (pci_q) begin
            host_data_pins_out <= pci_ad_out; // see R15 see R5
            host_data_pins_oe <= pci_ad_oe;
            host_port_in <= {HD_W{1'b0}};
            pci_ad_in <= hd_s;
        end else begin
            host_data_pins_out <= host_port_out & hp_lane_mask;
            // Upper lanes stay high impedance in 16-bit mode
            host_data_pins_oe <= host_port_oe & hp_lane_mask; // see R1 see R2
            host_port_in <= hd_s & hp_lane_mask;
            pci_ad_in <= {HD_W{1'b0}};
        end
    end

    // Serial-one versus ATM pins; the strap is frozen so ownership never flips
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            shared_pins_out <= {SHARED_W{1'b0}};
            shared_pins_oe <= {SHARED_W{1'b0}};
            sp1_shared_in <= {SHARED_W{1'b0}};
            atm_shared_in <= {SHARED_W{1'b0}};
        end else if (atm_q) begin
            shared_pins_out <= atm_shared_out; // see R14 see R5
            shared_pins_oe <= atm_shared_oe;
            sp1_shared_in <= {SHARED_W{1'b0}};
            atm_shared_in <= sh_s;
        end else begin
            shared_pins_out <= sp1_shared_out; // see R11 see R12
            shared_pins_oe <= sp1_shared_oe;
            sp1_shared_in <= sh_s;
            atm_shared_in <= {SHARED_W{1'b0}};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sp1_solo_pins_out <= {SP1_SOLO_W{1'b0}};
            sp1_solo_pins_oe <= {SP1_SOLO_W{1'b0}};
            atm_solo_pins_out <= {ATM_SOLO_W{1'b0}};
            atm_solo_pins_oe <= {ATM_SOLO_W{1'b0}};
        end else begin
            // The disabled peripheral's standalone pins are tied off in high impedance
            sp1_solo_pins_out <= atm_q ? {SP1_SOLO_W{1'b0}} : sp1_solo_out; // see R14
            sp1_solo_pins_oe <= atm_q ? {SP1_SOLO_W{1'b0}} : sp1_solo_oe; // see R14
            atm_solo_pins_out <= atm_q ? atm_solo_out : {ATM_SOLO_W{1'b0}}; // see R12
            atm_solo_pins_oe <= atm_q ? atm_solo_oe : {ATM_SOLO_W{1'b0}}; // see R12
        end
    end
endmodule : rspm_top
`default_nettype wire

// file: tb/rspm_properties.sv
// Checker for the strap pin multiplexer, bound to rspm_top.
// Assumes GPIO registers change only through completed APB writes.
`timescale 1ns/1ns
`default_nettype none
module rspm_properties (
    // Bus
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Status and pins
    input wire logic host_port_16bit,
    input wire logic host_port_32bit,
    input wire logic pci_enable,
    input wire logic atm_enable,
    input wire logic [31:0] host_data_pins_oe,
    input wire logic [15:0] gpio_pins_oe,
    input wire logic [15:0] gpio_pins_out,
    input wire logic [15:0] periph_gp_oe,
    input wire logic [3:0] shared_pins_oe,
    input wire logic [3:0] sp1_shared_oe,
    input wire logic [3:0] atm_shared_oe,
    input wire logic [3:0] sp1_solo_pins_oe
);
    import rspm_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [15:0] en_q, dir_q, val_q;
    // Shadow registers land on the same edge as the design's own copy
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            en_q <= RSPM_GPIO_EN_RST;
            dir_q <= RSPM_GPIO_DIR_RST;
            val_q <= RSPM_GPIO_OUT_RST;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == RSPM_GPIO_EN_OFS) en_q <= pwdata[15:0];
            if (paddr == RSPM_GPIO_DIR_OFS) dir_q <= pwdata[15:0];
            if (paddr == RSPM_GPIO_OUT_OFS) val_q <= pwdata[15:0];
        end
    end
    narrow_lanes_a: assert property (
        host_port_16bit && !pci_enable |-> host_data_pins_oe[31:16] == 16'h0000)
        else $error("upper host lanes driven");
    width_onehot_a: assert property (
        rstn[*4] |-> host_port_16bit ^ host_port_32bit)
        else $error("host width not one-hot");
    strap_hold_a: assert property (
        rstn[*5] |-> $stable({host_port_16bit, pci_enable, atm_enable}))
        else $error("strap mode moved");
    serial_owner_a: assert property (
        rstn[*4] ##0 !atm_enable |=> shared_pins_oe == $past(sp1_shared_oe))
        else $error("shared pins not serial");
    atm_owner_a: assert property (
        rstn[*4] ##0 atm_enable |=>
        shared_pins_oe == $past(atm_shared_oe) && sp1_solo_pins_oe == 4'h0)
        else $error("shared pins not atm");
    clock_default_a: assert property (
        rstn[*2] ##0 en_q[2:1] == 2'h0 |=> gpio_pins_oe[2:1] == $past(periph_gp_oe[2:1]))
        else $error("clock outputs lost");
    gpio_drive_a: assert property (
        rstn[*2] ##0 en_q[0] |=> gpio_pins_oe[0] == $past(dir_q[0]) &&
        (!gpio_pins_oe[0] || gpio_pins_out[0] == $past(val_q[0])))
        else $error("gpio line wrong");
    pci_lines_a: assert property (
        rstn[*4] ##0 pci_enable |=> gpio_pins_oe[15:9] == $past(periph_gp_oe[15:9]))
        else $error("pci lines not owned");
    float_lines_a: assert property (
        rstn[*4] ##0 !pci_enable |=>
        (gpio_pins_oe & ~($past(en_q) | RSPM_DEFAULT_ALT_MASK)) == 16'h0000)
        else $error("idle gpio line driven");
    cover property (rstn[*4] ##0 atm_enable && pci_enable);
    cover property (rstn[*4] ##0 host_port_16bit);
    cover property (en_q[0] && dir_q[0]);
endmodule : rspm_properties
bind rspm_top rspm_properties rspm_properties_i (.mclk, .rstn, .psel, .penable, .pwrite,
    .pready, .paddr, .pwdata, .host_port_16bit, .host_port_32bit, .pci_enable, .atm_enable,
    .host_data_pins_oe, .gpio_pins_oe, .gpio_pins_out, .periph_gp_oe, .shared_pins_oe,
    .sp1_shared_oe, .atm_shared_oe, .sp1_solo_pins_oe);
`default_nettype wire

// file: tb/rspm_board.sv
// Board model: strap resistors plus an outside controller on shared lines.
// Assumes the bench picks the strap mix before each reset.
`timescale 1ns/1ns
`default_nettype none
module rspm_board (
    // Clock, reset, strap mix
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] sel,
    // Pins
    output logic atm_port_select_strap,
    output logic pci_func_strap,
    output logic [31:0] host_data_pins_in,
    output logic [15:0] gpio_pins_in,
    output logic [3:0] shared_pins_in
);
    logic [15:0] cnt_q = 16'h0000;
    always @(posedge mclk) cnt_q <= cnt_q + 16'h0001;
    // Straps steady in reset, then the lines toggle so a late sample shows
    assign atm_port_select_strap = rstn ? cnt_q[0] : sel[1];
    assign pci_func_strap = rstn ? cnt_q[1] : sel[2];
    assign host_data_pins_in = rstn ? {cnt_q, ~cnt_q} : {26'h0, sel[0], 5'h00};
    assign gpio_pins_in = ~cnt_q;
    assign shared_pins_in = cnt_q[3:0];
endmodule : rspm_board
`default_nettype wire

// file: tb/rspm_tb_top.sv
// Bench: resets under each strap mix, then checks pins and GPIO registers.
// Assumes rspm_board supplies straps and pin traffic.
`timescale 1ns/1ns
`default_nettype none
module reset_strap_pin_mux_tb_top;
    import rspm_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, hd_oe, hd_in;
    logic [31:0] rv [5];
    logic [2:0] sel = 3'h0;
    logic pready, pslverr, m16, m32, pci_en, atm_en, atm_s, pci_s;
    logic [15:0] gp_out, gp_oe, gp_in, en, dir, val, eoe, eout, pg_in, ein;
    logic [3:0] sh_in, sh_oe, so_oe, ao_oe, sh_out, sp_in, at_in, so_out, ao_out;
    logic [31:0] hd_out, hp_in, pci_in;
    // Pin history: h3 holds the pins three edges back, the pin-to-core latency
    logic [51:0] h1, h2, h3;
    logic alt;
    int bad_count = 0, tests_run = 0, seed = 32'h5a23051e, i, m, k;
    always #20 mclk = ~mclk;
    always @(posedge mclk) {h3, h2, h1} <= {h2, h1, hd_in, gp_in, sh_in};
    rspm_top rspm_top_i (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .atm_port_select_strap(atm_s), .pci_func_strap(pci_s),
        .host_data_pins_in(hd_in), .host_data_pins_out(hd_out), .host_data_pins_oe(hd_oe),
        .host_port_out(rv[0]), .host_port_oe(rv[1]), .host_port_in(hp_in),
        .pci_ad_out(~rv[0]), .pci_ad_oe(rv[2]), .pci_ad_in(pci_in), .host_port_16bit(m16),
        .host_port_32bit(m32), .pci_enable(pci_en), .atm_enable(atm_en),
        .gpio_pins_in(gp_in), .gpio_pins_out(gp_out), .gpio_pins_oe(gp_oe),
        .periph_gp_out(rv[3][15:0]), .periph_gp_oe(rv[3][31:16]), .periph_gp_in(pg_in),
        .shared_pins_in(sh_in), .shared_pins_out(sh_out), .shared_pins_oe(sh_oe),
        .sp1_shared_out(rv[4][3:0]), .sp1_shared_oe(rv[4][7:4]), .sp1_shared_in(sp_in),
        .atm_shared_out(rv[4][11:8]), .atm_shared_oe(rv[4][15:12]), .atm_shared_in(at_in),
        .sp1_solo_out(rv[4][19:16]), .sp1_solo_oe(rv[4][23:20]), .sp1_solo_pins_out(so_out),
        .sp1_solo_pins_oe(so_oe), .atm_solo_out(rv[4][27:24]), .atm_solo_oe(rv[4][31:28]),
        .atm_solo_pins_out(ao_out), .atm_solo_pins_oe(ao_oe));
    rspm_board rspm_board_i (.mclk, .rstn, .sel, .atm_port_select_strap(atm_s),
        .pci_func_strap(pci_s), .host_data_pins_in(hd_in), .gpio_pins_in(gp_in),
        .shared_pins_in(sh_in));
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, pready, 1'b1);
            summarize();
        end
    endtask : apb
    task automatic shake;
        @(posedge mclk);
        foreach (rv[j]) rv[j] <= $random(seed);
        repeat (2) @(posedge mclk);
    endtask : shake
    initial begin
        foreach (rv[j]) rv[j] = 32'h0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        for (m = 0; m < 8; m++) begin
            @(posedge mclk);
            rstn <= 1'b0;
            sel <= m[2:0];
            repeat (4) @(posedge mclk);
            rstn <= 1'b1;
            repeat (4) @(posedge mclk);
            chk({pci_en, atm_en, m32, m16}, {m[2], m[1], m[0], !m[0]});
            apb(1'b1, RSPM_STRAP_OFS, 32'hffffffff);
            apb(1'b0, RSPM_STRAP_OFS, 32'h0);
            chk(rd, m & 7);
            apb(1'b0, RSPM_GPIO_EN_OFS, 32'h0);
            chk(rd, RSPM_GPIO_EN_RST);
            shake();
            chk(hd_oe, m[2] ? rv[2] : m[0] ? rv[1] : {16'h0, rv[1][15:0]});
            chk(sh_oe, m[1] ? rv[4][15:12] : rv[4][7:4]);
            chk({ao_oe, so_oe}, m[1] ? {rv[4][31:28], 4'h0} : {4'h0, rv[4][23:20]});
            chk(hd_out, m[2] ? ~rv[0] : m[0] ? rv[0] : {16'h0, rv[0][15:0]});
            chk(hp_in, m[2] ? 32'h0 : m[0] ? h3[51:20] : {16'h0, h3[35:20]});
            chk(pci_in, m[2] ? h3[51:20] : 32'h0);
            chk(sh_out, m[1] ? rv[4][11:8] : rv[4][3:0]);
            chk({at_in, sp_in}, m[1] ? {h3[3:0], 4'h0} : {4'h0, h3[3:0]});
            chk({ao_out, so_out}, m[1] ? {rv[4][27:24], 4'h0} : {4'h0, rv[4][19:16]});
            for (k = 0; k < 4; k++) begin
                {dir, en} = $random(seed);
                {eout, val} = $random(seed);
                apb(1'b1, RSPM_GPIO_EN_OFS, {16'h0, en});
                apb(1'b1, RSPM_GPIO_DIR_OFS, {16'h0, dir});
                apb(1'b1, RSPM_GPIO_OUT_OFS, {16'h0, val});
                shake();
                for (i = 0; i < 16; i++) begin
                    alt = (m[2] && i > 8) || (!en[i] && i inside {1, 2, 8});
                    {eoe[i], eout[i]} = alt ? {rv[3][16 + i], rv[3][i]} :
                        {en[i] && dir[i], val[i]};
                    ein[i] = alt && h3[4 + i];
                end
                chk(gp_oe, eoe);
                chk(gp_out & eoe, eout & eoe);
                chk(pg_in, ein);
                apb(1'b0, RSPM_GPIO_IN_OFS, 32'h0);
                chk(rd, {16'h0, h3[19:4]});
                apb(1'b0, RSPM_GPIO_DIR_OFS, 32'h0);
                chk(rd, {16'h0, dir});
            end
            apb(1'b0, 8'h14, 32'h0);
            chk({31'h0, err}, 32'h1);
            $display("strap mix %0d done", m);
        end
        summarize();
    end
endmodule : reset_strap_pin_mux_tb_top
`default_nettype wire
